// ===== design/bitx_pkg.sv
/*
 * package for the bit-oriented file-register instruction executor:
 * instruction word layout, opcode patterns and reset values.
 * assumes a 14-bit instruction word and an 8-bit data path.
 */
package bitx_pkg;

	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int BSEL_W = 3;

	// field positions
	localparam int CLASS_HI = 13;
	localparam int CLASS_LO = 12;
	localparam int SUBOP_HI = 11;
	localparam int SUBOP_LO = 10;
	localparam int BSEL_HI = 9;
	localparam int BSEL_LO = 7;
	localparam int ADDR_HI = 6;
	localparam int ADDR_LO = 0;

	// opcode patterns
	localparam logic [1:0] CLASS_BIT = 2'h1;
	localparam logic [1:0] SUB_CLEAR = 2'h0;
	localparam logic [1:0] SUB_SET = 2'h1;
	localparam logic [1:0] SUB_TSTZ = 2'h2;
	localparam logic [1:0] SUB_TSTO = 2'h3;

	// reset values
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;

	typedef enum logic [4:0] {
		BITX_NONE = 5'h01,
		BITX_CLEAR = 5'h02,
		BITX_SET = 5'h04,
		BITX_TSTZ = 5'h08,
		BITX_TSTO = 5'h10
	} bitx_op_t;

endpackage

// ===== design/bitx_dec_if.sv
/*
 * carrier between the executor top and its decoder.
 * assumes both ends run on the same clock.
 */
interface bitx_dec_if;
	import bitx_pkg::*;
	logic [INSTR_W-1:0] instr;
	bitx_op_t op;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] mask;

	modport dec (input instr, output op, output addr, output mask);
	modport top (output instr, input op, input addr, input mask);
endinterface

// ===== design/bitx_decoder.sv
/*
 * combinational decoder of the four bit instructions.
 * assumes the instruction word is stable for the execute cycle.
 */
module bitx_decoder
	import bitx_pkg::*;
(
	bitx_dec_if.dec dec
);

	// one-hot bit mask, shared by set, clear and test
	function automatic logic [DATA_W-1:0] bit_mask(input logic [BSEL_W-1:0] sel);
		bit_mask = 8'h01 << sel;
	endfunction

	always_comb begin
		dec.op = BITX_NONE;
		if (dec.instr[CLASS_HI:CLASS_LO] == CLASS_BIT) begin
			case (dec.instr[SUBOP_HI:SUBOP_LO])
				SUB_CLEAR: dec.op = BITX_CLEAR;
				SUB_SET: dec.op = BITX_SET;
				SUB_TSTZ: dec.op = BITX_TSTZ;
				SUB_TSTO: dec.op = BITX_TSTO;
				default: dec.op = BITX_NONE;
			endcase
		end
		dec.addr = dec.instr[ADDR_HI:ADDR_LO];
		dec.mask = bit_mask(dec.instr[BSEL_HI:BSEL_LO]);
	end

endmodule

// ===== design/bitx_exec.sv
/*
 * bit-oriented file-register instruction executor of a small 8-bit core.
 * assumes the fetch pipeline presents one instruction per cycle with a
 * valid strobe, and the register file answers reads combinationally.
 */
module bitx_exec
	import bitx_pkg::*;
(
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_n_in,
	// instruction from fetch pipeline
	input wire logic instr_valid_in,
	input wire logic [INSTR_W-1:0] instr_in,
	// register file read port
	output logic [ADDR_W-1:0] rd_addr_out,
	input wire logic [DATA_W-1:0] rd_data_in,
	// register file write port
	output logic wr_en_out,
	output logic [ADDR_W-1:0] wr_addr_out,
	output logic [DATA_W-1:0] wr_data_out,
	// pipeline control
	output logic flush_out,
	output logic busy_out,
	output logic status_we_out
);

	// ****************************************
	// reset release
	// ****************************************
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ****************************************
	// elaboration checks
	// ****************************************
	// the mask and the field slices assume one data bit per select code
	if (DATA_W != (1 << BSEL_W)) begin : g_bad_bsel
		$error("bit select width does not cover the data byte");
	end
	if (ADDR_W != ADDR_HI - ADDR_LO + 1 || BSEL_W != BSEL_HI - BSEL_LO + 1) begin : g_bad_field
		$error("instruction field widths disagree with their positions");
	end
	if (INSTR_W != CLASS_HI + 1) begin : g_bad_word
		$error("instruction word width disagrees with the class field");
	end

	// ****************************************
	// decode
	// ****************************************
	bitx_dec_if dif ();
	assign dif.instr = instr_in;

	bitx_decoder u_dec (
		.dec(dif.dec)
	);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic wr_en;
		logic [ADDR_W-1:0] wr_addr;
		logic [DATA_W-1:0] wr_data;
		logic flush;
		logic busy;
	} bitx_state_t;

	bitx_state_t s_q;
	bitx_state_t s_d;
	logic bit_val;
	logic [DATA_W-1:0] rd_byte;

	// ****************************************
	// read bypass
	// ****************************************
	// a write of the last cycle reaches the register file only at this edge;
	// without the bypass a back-to-back access to the same byte reads stale data
	assign rd_byte = (s_q.wr_en && s_q.wr_addr == dif.addr) ?
		s_q.wr_data : rd_data_in;

	// only the chosen bit is looked at; the rest of the byte is masked out
	assign bit_val = |(rd_byte & dif.mask);

	always_comb begin
		s_d = s_q;
		s_d.wr_en = 1'b0;
		s_d.flush = 1'b0;
		s_d.busy = 1'b0;
		// the fetched word in the cycle after a taken skip is a discarded slot
		if (instr_valid_in && !s_q.flush) begin
			case (dif.op)
				BITX_CLEAR: begin
					s_d.wr_en = 1'b1;
					s_d.wr_addr = dif.addr;
					s_d.wr_data = rd_byte & ~dif.mask;
				end
				BITX_SET: begin
					s_d.wr_en = 1'b1;
					s_d.wr_addr = dif.addr;
					s_d.wr_data = rd_byte | dif.mask;
				end
				BITX_TSTZ: begin
					s_d.flush = !bit_val;
					s_d.busy = !bit_val;
				end
				BITX_TSTO: begin
					s_d.flush = bit_val;
					s_d.busy = bit_val;
				end
				default: begin
					s_d.wr_en = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{wr_en: 1'b0, wr_addr: ADDR_RST, wr_data: DATA_RST,
				flush: 1'b0, busy: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// read address follows the current word so data is ready this cycle
	assign rd_addr_out = dif.addr;
	assign wr_en_out = s_q.wr_en;
	assign wr_addr_out = s_q.wr_addr;
	assign wr_data_out = s_q.wr_data;
	assign flush_out = s_q.flush;
	assign busy_out = s_q.busy;
	// bit instructions never touch status flags
	assign status_we_out = 1'b0;

	// ****************************************
	// checks
	// ****************************************
	a_clear_bit_zero: assert property (@(posedge clock_in) disable iff (!rst_n)
		(instr_valid_in && !flush_out && dif.op == BITX_CLEAR) |=>
		(wr_en_out && (wr_data_out & $past(dif.mask)) == 8'h00))
		else $error("clear did not zero bit");

	a_set_bit_one: assert property (@(posedge clock_in) disable iff (!rst_n)
		(instr_valid_in && !flush_out && dif.op == BITX_SET) |=>
		(wr_en_out && (wr_data_out & $past(dif.mask)) == $past(dif.mask)))
		else $error("set did not raise bit");

	a_skip_zero_taken: assert property (@(posedge clock_in) disable iff (!rst_n)
		(instr_valid_in && !flush_out && dif.op == BITX_TSTZ && !bit_val) |=> flush_out)
		else $error("skip-if-zero not taken");

	a_skip_one_taken: assert property (@(posedge clock_in) disable iff (!rst_n)
		(instr_valid_in && !flush_out && dif.op == BITX_TSTO && bit_val) |=> flush_out)
		else $error("skip-if-one not taken");

	a_flush_one_slot: assert property (@(posedge clock_in) disable iff (!rst_n)
		flush_out |=> !flush_out && !wr_en_out)
		else $error("flush longer than one slot");

	a_addr_pass: assert property (@(posedge clock_in) disable iff (!rst_n)
		(instr_valid_in && !flush_out && dif.op inside {BITX_CLEAR, BITX_SET}) |=>
		wr_addr_out == $past(instr_in[ADDR_HI:ADDR_LO]))
		else $error("write address wrong");

	a_zero_no_skip: assert property (@(posedge clock_in) disable iff (!rst_n)
		(instr_valid_in && !flush_out && dif.op == BITX_TSTZ && bit_val) |=> !flush_out)
		else $error("skip-if-zero taken on one");

	a_one_no_skip: assert property (@(posedge clock_in) disable iff (!rst_n)
		(instr_valid_in && !flush_out && dif.op == BITX_TSTO && !bit_val) |=> !flush_out)
		else $error("skip-if-one taken on zero");

	a_other_bits_kept: assert property (@(posedge clock_in) disable iff (!rst_n)
		(instr_valid_in && !flush_out && dif.op inside {BITX_CLEAR, BITX_SET}) |=>
		((wr_data_out ^ $past(rd_byte)) & ~$past(dif.mask)) == 8'h00 && !status_we_out)
		else $error("other bits altered");

	a_bypass_fresh: assert property (@(posedge clock_in) disable iff (!rst_n)
		(instr_valid_in && !flush_out && wr_en_out && wr_addr_out == dif.addr &&
		dif.op inside {BITX_CLEAR, BITX_SET}) |=>
		((wr_data_out ^ $past(wr_data_out)) & ~$past(dif.mask)) == 8'h00)
		else $error("back-to-back write lost a bit");

	a_test_no_write: assert property (@(posedge clock_in) disable iff (!rst_n)
		(instr_valid_in && !flush_out && dif.op inside {BITX_TSTZ, BITX_TSTO}) |=> !wr_en_out)
		else $error("test instruction wrote a register");

	a_nonbit_ignored: assert property (@(posedge clock_in) disable iff (!rst_n)
		(instr_valid_in && dif.op == BITX_NONE) |=> !wr_en_out && !flush_out)
		else $error("non-bit word acted on");

	a_busy_tracks_flush: assert property (@(posedge clock_in) disable iff (!rst_n)
		busy_out == flush_out)
		else $error("busy and flush disagree");

	// a discarded slot may only follow a test that was really executed
	a_flush_after_test: assert property (@(posedge clock_in) disable iff (!rst_n)
		flush_out |-> $past(instr_valid_in) && $past(dif.op == BITX_TSTZ || dif.op == BITX_TSTO))
		else $error("flush without a test");

endmodule

// ===== bench/bitx_regfile_model.sv
/*
 * register file partner of the bit executor: 128 bytes, read at once.
 * assumes one clock, and writes that land on its rising edge.
 */
module bitx_regfile_model
	import bitx_pkg::*;
(
	// clock
	input wire logic clock_in,
	// read port
	input wire logic [ADDR_W-1:0] rd_addr_in,
	output logic [DATA_W-1:0] rd_data_out,
	// write port
	input wire logic wr_en_in,
	input wire logic [ADDR_W-1:0] wr_addr_in,
	input wire logic [DATA_W-1:0] wr_data_in
);
	logic [DATA_W-1:0] mem [128];
	// read in the same cycle, so the executor can modify and write back
	assign rd_data_out = mem[rd_addr_in];
	always @(posedge clock_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end
endmodule

// ===== bench/bitx_exec_bench.sv
/*
 * self-checking bench of the bit executor with a register file model.
 * assumes inputs change at the falling edge and outputs settle after rising.
 */
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_errors++; \
	$display("[ERR] %s exp %h got %h", nm, ex, got); end end
module bitx_exec_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import bitx_pkg::*;
	logic clk = 0;
	logic rst_n = 0;
	logic vld = 0;
	logic [INSTR_W-1:0] ins = '0;
	logic [ADDR_W-1:0] rd_addr, wr_addr;
	logic [DATA_W-1:0] rd_data, wr_data;
	logic wr_en, flush, busy, st_we;
	int n_errors = 0;
	int total_checks = 0;
	initial forever #12.5 clk = ~clk;
	bitx_exec dut (.clock_in(clk), .reset_n_in(rst_n), .instr_valid_in(vld),
		.instr_in(ins), .rd_addr_out(rd_addr), .rd_data_in(rd_data), .wr_en_out(wr_en),
		.wr_addr_out(wr_addr), .wr_data_out(wr_data), .flush_out(flush),
		.busy_out(busy), .status_we_out(st_we));
	bitx_regfile_model m (.clock_in(clk), .rd_addr_in(rd_addr), .rd_data_out(rd_data),
		.wr_en_in(wr_en), .wr_addr_in(wr_addr), .wr_data_in(wr_data));
	// ************************
	// shared tasks
	// ************************
	task test_done;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	function automatic logic [13:0] w(logic [1:0] op, logic [2:0] b, logic [6:0] f);
		return {CLASS_BIT, op, b, f};
	endfunction
	// present a word for one cycle and look just after the edge that takes it
	task put(input logic v, input logic [13:0] wd);
		@(negedge clk);
		vld = v;
		ins = wd;
		@(posedge clk);
		#1;
	endtask
	// ************************
	// scenarios
	// ************************
	task t_clear;
		m.mem[7'h7f] = 8'hc7;
		put(1'b1, w(SUB_CLEAR, 3'h7, 7'h7f));
		`CHK("wr_en", 1'b1, wr_en)
		`CHK("wr_addr", 7'h7f, wr_addr)
		`CHK("rd_addr", 7'h7f, rd_addr)
		`CHK("wr_data", 8'h47, wr_data)
		`CHK("status_we", 1'b0, st_we)
		put(1'b1, 14'h0f80);
		`CHK("wr_en", 1'b0, wr_en)
		`CHK("flush", 1'b0, flush)
	endtask
	task t_set;
		m.mem[7'h00] = 8'h0a;
		put(1'b1, w(SUB_SET, 3'h7, 7'h00));
		`CHK("wr_data", 8'h8a, wr_data)
		put(1'b1, w(SUB_SET, 3'h0, 7'h00));
		`CHK("wr_data", 8'h8b, wr_data)
		`CHK("wr_en", 1'b1, wr_en)
		put(1'b0, '0);
	endtask
	// register holds bit 1 only; the word after the test tries to set bit 2
	task t_skip(input logic [1:0] op, input logic b);
		logic sk;
		sk = (op == SUB_TSTZ) ^ b;
		m.mem[7'h10] = 8'h02;
		put(1'b1, w(op, {2'h0, b}, 7'h10));
		`CHK("flush", sk, flush)
		`CHK("busy", sk, busy)
		put(1'b1, w(SUB_SET, 3'h2, 7'h10));
		`CHK("wr_en", ~sk, wr_en)
		`CHK("flush", 1'b0, flush)
		put(1'b0, '0);
		`CHK("reg", sk ? 8'h02 : 8'h06, m.mem[7'h10])
	endtask
	// ************************
	// main sequence
	// ************************
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1;
		repeat (2) @(negedge clk);
		`CHK("wr_en", 1'b0, wr_en)
		`CHK("flush", 1'b0, flush)
		t_clear();
		t_set();
		t_skip(SUB_TSTZ, 1'b0);
		t_skip(SUB_TSTZ, 1'b1);
		t_skip(SUB_TSTO, 1'b0);
		t_skip(SUB_TSTO, 1'b1);
		test_done();
	end
	// a hang costs at most some 800 cycles
	initial begin
		#20us;
		n_errors++;
		test_done();
	end
endmodule
